// *** bench/gpg_pin_model.sv ***
// Far-side circuitry of one port: drives, pulls up or leaves pins floating.
`timescale 1ns/1ps
module gpg_pin_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] lvl_o
);
  logic [7:0] float_pat = 8'h55;

  // A floating pin toggles every cycle so a stale level never looks valid.
  always_ff @(posedge mclk_i) begin
    float_pat <= ~float_pat;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl_o[i] = pin_oe_i[i] ? pin_o_i[i] : ext_en_i[i] ? ext_val_i[i] :
                 pullup_i[i] ? 1'b1 : float_pat[i];
    end
  end
endmodule : gpg_pin_model

// *** bench/gpg_port_group_assertions.sv ***
// Checker of pin drive, read answers and input routing of the port group.
`timescale 1ns/1ps
module gpg_assertions
  import gpg_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic       ce_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_hit_o,
  input wire logic [7:0] port0_pin_i,
  input wire logic [7:0] port0_pin_o,
  input wire logic [7:0] port0_pin_oe_o,
  input wire logic [7:0] port0_pullup_o,
  input wire logic [7:0] port1_pin_i,
  input wire logic [7:0] port1_pin_o,
  input wire logic [7:0] port1_pin_oe_o,
  input wire logic [7:0] port1_pullup_o,
  input wire logic [7:0] port2_pin_i,
  input wire logic       serial_tx_sel_i,
  input wire logic       serial_tx_data_i,
  input wire logic [3:0] ext_irq_in_0_o,
  input wire logic       serial_rx_data_o,
  input wire logic [3:0] analog_in_0_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_wr_dir0;
    ce_i && sfr_wr_i && sfr_addr_i == GPG_ADDR_PT0_DIR;
  endsequence
  sequence s_run2;
    ce_i && rst_b_i ##1 ce_i;
  endsequence

  property p_dir_oe;
    s_wr_dir0 ##1 ce_i |=> port0_pin_oe_o[3:0] == ~$past(sfr_wdata_i[3:0], 2);
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("oe not from dir");
  property p_spare_oe;
    port0_pin_oe_o[7:4] == 4'h0 && (port1_pin_oe_o & ~GPG_MASK_PT1) == 8'h00;
  endproperty
  a_spare_oe: assert property (p_spare_oe) else $error("spare pin on");
  property p_pu_gate;
    (port0_pullup_o & port0_pin_oe_o) == 8'h00 &&
    (port1_pullup_o & port1_pin_oe_o) == 8'h00;
  endproperty
  a_pu_gate: assert property (p_pu_gate) else $error("pull-up on out");
  property p_undriven;
    (port0_pin_o & ~port0_pin_oe_o) == 8'h00 &&
    (port1_pin_o & ~port1_pin_oe_o) == 8'h00;
  endproperty
  a_undriven: assert property (p_undriven) else $error("idle drive");
  property p_p2_read;
    ce_i && sfr_rd_i && sfr_addr_i == GPG_ADDR_PT2_INPUT && $past(rst_b_i) &&
    $past(ce_i) |=> sfr_hit_o && sfr_rdata_o == {4'h0, $past(port2_pin_i[3:0], 2)};
  endproperty
  a_p2_read: assert property (p_p2_read) else $error("port2 read");
  property p_unmapped;
    ce_i && sfr_rd_i && !(sfr_addr_i inside {8'h00, 8'h01, 8'h02, 8'h05,
    8'h20, 8'h21, 8'h25, 8'h30, 8'h31, 8'h35}) |=> sfr_rdata_o == 8'h00 && !sfr_hit_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_alt_p0;
    s_run2 |=> ext_irq_in_0_o == $past(port0_pin_i[3:0], 2);
  endproperty
  a_alt_p0: assert property (p_alt_p0) else $error("irq route");
  property p_alt_p1;
    s_run2 |=> serial_rx_data_o == $past(port1_pin_i[3], 2);
  endproperty
  a_alt_p1: assert property (p_alt_p1) else $error("rx route");
  property p_alt_p2;
    s_run2 |=> analog_in_0_o == $past(port2_pin_i[3:0], 2);
  endproperty
  a_alt_p2: assert property (p_alt_p2) else $error("analog route");
  property p_tx_alt;
    ce_i && serial_tx_sel_i ##1 port1_pin_oe_o[4] |->
    port1_pin_o[4] == $past(serial_tx_data_i);
  endproperty
  a_tx_alt: assert property (p_tx_alt) else $error("tx not routed");
  property p_freeze;
    !ce_i |=> $stable(sfr_rdata_o) && $stable(port0_pin_oe_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while held");
endmodule : gpg_assertions

bind gpg_port_group gpg_assertions u_chk (.*);

// *** bench/tb_gpio_port_group.sv ***
// Self-checking bench of the port group with pin models on ports 0, 1, 5.
`timescale 1ns/1ps
module tb_gpio_port_group;
  import gpg_pkg::*;
  logic       mclk_i, rst_b_i, ce_i, sfr_wr_i, sfr_rd_i, sfr_hit_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, port2_pin_i, rd_v;
  logic [7:0] p_in [3], p_o [3], p_oe [3], p_pu [3], ext_v [3], ext_e [3];
  logic       tx_s, tx_d, tb_s, tb_d, ta_s, ta_d;
  logic [3:0] irq0, an;
  logic       stop, trig, rx, prog, tbi, irq5, ta0, ta1;
  int         miscompares = 0;
  int         tests_run = 0;
  localparam logic [7:0] DIR [3] = '{8'h20, 8'h21, 8'h25};
  localparam logic [7:0] LAT [3] = '{8'h00, 8'h01, 8'h05};
  localparam logic [7:0] PU  [3] = '{8'h30, 8'h31, 8'h35};
  localparam logic [7:0] MSK [3] = '{GPG_MASK_PT0, GPG_MASK_PT1, GPG_MASK_PT5};

  gpg_port_group uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .sfr_hit_o(sfr_hit_o), .port0_pin_i(p_in[0]), .port0_pin_o(p_o[0]),
    .port0_pin_oe_o(p_oe[0]), .port0_pullup_o(p_pu[0]),
    .port1_pin_i(p_in[1]), .port1_pin_o(p_o[1]), .port1_pin_oe_o(p_oe[1]),
    .port1_pullup_o(p_pu[1]), .port2_pin_i(port2_pin_i),
    .port5_pin_i(p_in[2]), .port5_pin_o(p_o[2]), .port5_pin_oe_o(p_oe[2]),
    .port5_pullup_o(p_pu[2]), .serial_tx_sel_i(tx_s),
    .serial_tx_data_i(tx_d), .timer_b_out_sel_i(tb_s),
    .timer_b_out_i(tb_d), .timer_a_out_sel_i(ta_s), .timer_a_out_i(ta_d),
    .ext_irq_in_0_o(irq0), .timer_out_stop_in_o(stop),
    .adc_trigger_in_o(trig), .serial_rx_data_o(rx),
    .prog_mode_select_in_o(prog), .analog_in_0_o(an), .timer_b_in_o(tbi),
    .ext_irq_in_5_o(irq5), .timer_a_in_0_o(ta0), .timer_a_in_1_o(ta1));

  for (genvar k = 0; k < 3; k++) begin : g_pin
    gpg_pin_model u_pin (.mclk_i(mclk_i), .pin_o_i(p_o[k]),
      .pin_oe_i(p_oe[k]), .pullup_i(p_pu[k]), .ext_en_i(ext_e[k]),
      .ext_val_i(ext_v[k]), .lvl_o(p_in[k]));
  end

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic test_done;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : idle

  // Ends one cycle after the strobe so pin outputs have followed.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge mclk_i);
    sfr_wr_i = 1'b0;
    @(negedge mclk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge mclk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge mclk_i);
    sfr_rd_i = 1'b0;
    rd_v = sfr_rdata_o;
  endtask : rd

  task automatic t_reset;
    for (int k = 0; k < 3; k++) begin
      chk(p_oe[k], 8'h00);
      rd(DIR[k]);
      chk(rd_v, GPG_RST_DIR);
      rd(PU[k]);
      chk(rd_v, GPG_RST_PU);
    end
  endtask : t_reset

  task automatic t_ports;
    for (int k = 0; k < 3; k++) begin
      wr(PU[k], 8'hFF);
      chk(p_pu[k], MSK[k]);
      rd(PU[k]);
      chk(rd_v, MSK[k]);
      wr(DIR[k], 8'h00);
      chk(p_o[k], GPG_RST_LATCH);
      chk(p_pu[k], 8'h00);
      wr(LAT[k], 8'hFF);
      chk(p_oe[k], MSK[k]);
      chk(p_o[k], MSK[k]);
      rd(LAT[k]);
      chk(rd_v, MSK[k]);
      rd(DIR[k]);
      chk(rd_v, ~MSK[k]);
      wr(DIR[k], 8'hFF);
      wr(PU[k], 8'h00);
      wr(LAT[k], 8'h00);
      chk(p_oe[k], 8'h00);
    end
  endtask : t_ports

  task automatic t_rmw;
    wr(GPG_ADDR_PT0_LATCH, 8'h0A);
    wr(GPG_ADDR_PT0_DIR, 8'hFC);
    ext_v[0] = 8'h05;
    idle(2);
    rd(GPG_ADDR_PT0_LATCH);
    chk(rd_v, 8'h06);
    chk(p_o[0], 8'h02);
    wr(GPG_ADDR_PT0_LATCH, rd_v | 8'h08);
    wr(GPG_ADDR_PT0_DIR, 8'hF0);
    rd(GPG_ADDR_PT0_LATCH);
    chk(rd_v, 8'h0E);
    wr(GPG_ADDR_PT0_DIR, 8'hFF);
  endtask : t_rmw

  task automatic t_p2;
    port2_pin_i = 8'h3C;
    idle(3);
    chk({4'h0, an}, 8'h0C);
    wr(GPG_ADDR_PT2_INPUT, 8'hFF);
    rd(GPG_ADDR_PT2_INPUT);
    chk(rd_v, 8'h0C);
    chk({7'h00, sfr_hit_o}, 8'h01);
  endtask : t_p2

  task automatic t_alt;
    ext_v = '{8'h09, 8'h88, 8'h19};
    idle(3);
    chk({irq0, stop, trig, rx, prog}, 8'h9F);
    chk({4'h0, tbi, irq5, ta0, ta1}, 8'h0F);
    wr(GPG_ADDR_PT1_DIR, 8'hEF);
    wr(GPG_ADDR_PT5_DIR, 8'hEE);
    {tx_s, tx_d, tb_s, tb_d, ta_s, ta_d} = 6'h3F;
    idle(2);
    chk(p_o[1], 8'h10);
    chk(p_o[2], 8'h11);
    {tx_s, tb_s, ta_s} = 3'h0;
    wr(GPG_ADDR_PT1_DIR, 8'hFF);
    wr(GPG_ADDR_PT5_DIR, 8'hFF);
  endtask : t_alt

  task automatic t_misc;
    wr(8'h10, 8'hFF);
    rd(8'h10);
    chk(rd_v, 8'h00);
    chk({7'h00, sfr_hit_o}, 8'h00);
    rd(GPG_ADDR_PT0_DIR);
    ce_i = 1'b0;
    rd(GPG_ADDR_PT0_PU);
    chk(rd_v, 8'hFF);
    ce_i = 1'b1;
    wr(GPG_ADDR_PT0_DIR, 8'h00);
    rst_b_i = 1'b0;
    idle(2);
    chk(p_oe[0], 8'h00);
    rst_b_i = 1'b1;
    rd(GPG_ADDR_PT0_DIR);
    chk(rd_v, GPG_RST_DIR);
  endtask : t_misc

  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    {sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = 18'h0;
    {tx_s, tx_d, tb_s, tb_d, ta_s, ta_d} = 6'h0;
    port2_pin_i = 8'hA5;
    ext_e = '{default: 8'hFF};
    ext_v = '{default: 8'h00};
    idle(5);
    rst_b_i = 1'b1;
    t_reset;
    t_ports;
    t_rmw;
    t_p2;
    t_alt;
    t_misc;
    test_done;
  end

  initial begin
    #100000;
    miscompares++;
    test_done;
  end
endmodule : tb_gpio_port_group

// *** verilog/gpg_pkg.sv ***
// Package with offsets, masks and reset values of the port group.
package gpg_pkg;

  // ==========================================================================
  // Register offsets in the special function register space
  // ==========================================================================
  localparam logic [7:0] GPG_ADDR_PT0_LATCH = 8'h00;
  localparam logic [7:0] GPG_ADDR_PT1_LATCH = 8'h01;
  localparam logic [7:0] GPG_ADDR_PT2_INPUT = 8'h02;
  localparam logic [7:0] GPG_ADDR_PT5_LATCH = 8'h05;
  localparam logic [7:0] GPG_ADDR_PT0_DIR   = 8'h20;
  localparam logic [7:0] GPG_ADDR_PT1_DIR   = 8'h21;
  localparam logic [7:0] GPG_ADDR_PT5_DIR   = 8'h25;
  localparam logic [7:0] GPG_ADDR_PT0_PU    = 8'h30;
  localparam logic [7:0] GPG_ADDR_PT1_PU    = 8'h31;
  localparam logic [7:0] GPG_ADDR_PT5_PU    = 8'h35;

  // ==========================================================================
  // Implemented bits of each port
  // ==========================================================================
  localparam logic [7:0] GPG_MASK_PT0 = 8'h0F;
  localparam logic [7:0] GPG_MASK_PT1 = 8'hD8;
  localparam logic [7:0] GPG_MASK_PT2 = 8'h0F;
  localparam logic [7:0] GPG_MASK_PT5 = 8'h19;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] GPG_RST_DIR   = 8'hFF;
  localparam logic [7:0] GPG_RST_LATCH = 8'h00;
  localparam logic [7:0] GPG_RST_PU    = 8'h00;
  localparam logic [7:0] GPG_RST_RDATA = 8'h00;

  // ==========================================================================
  // Bit positions of alternate functions
  // ==========================================================================
  localparam int GPG_BIT_PT0_STOP = 0;
  localparam int GPG_BIT_PT0_TRIG = 3;
  localparam int GPG_BIT_PT1_RX   = 3;
  localparam int GPG_BIT_PT1_TX   = 4;
  localparam int GPG_BIT_PT1_PROG = 7;
  localparam int GPG_BIT_PT5_TB   = 0;
  localparam int GPG_BIT_PT5_IRQ5 = 3;
  localparam int GPG_BIT_PT5_TA0  = 3;
  localparam int GPG_BIT_PT5_TA1  = 4;
  localparam int GPG_BIT_PT5_TAO  = 4;

endpackage : gpg_pkg

// *** verilog/gpg_port_group.sv ***
// Top of the port group: register access, four ports and function routing.
// Function
// - Port 0: four I/O bits, per-bit direction.
// - Port 0 input pull-ups set by software.
// - Reset makes every port pin an input.
// - Port 1: bits 3,4,6,7 with direction.
// - Port 1 input pull-ups set by software.
// - Port 2: four input-only bits, read pins.
// - Port 5: bits 0,3,4 with direction.
// - Port 5 pull-ups set per bit.
// - Eleven I/O pins, four input-only pins.
// - Eleven software-switched pull-ups.
// - Port 0 feeds interrupt, stop, trigger inputs.
// - Port 1 carries serial data, programming select.
// - Port 2 pins feed the analog inputs.
// - Port 5 carries interrupt and timer signals.
// - Direction 0 drives output, 1 is input.
// - Read: pin when input, latch when output.
// - Pull-up only while pin is an input.
// - Bit changes are whole-byte read-modify-writes.
`timescale 1ns/1ps
module gpg_port_group (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  // Register access from the processor.
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_hit_o,
  // Port 0 pins.
  input  wire logic [7:0] port0_pin_i,
  output logic      [7:0] port0_pin_o,
  output logic      [7:0] port0_pin_oe_o,
  output logic      [7:0] port0_pullup_o,
  // Port 1 pins.
  input  wire logic [7:0] port1_pin_i,
  output logic      [7:0] port1_pin_o,
  output logic      [7:0] port1_pin_oe_o,
  output logic      [7:0] port1_pullup_o,
  // Port 2 pins, input only.
  input  wire logic [7:0] port2_pin_i,
  // Port 5 pins.
  input  wire logic [7:0] port5_pin_i,
  output logic      [7:0] port5_pin_o,
  output logic      [7:0] port5_pin_oe_o,
  output logic      [7:0] port5_pullup_o,
  // Alternate output sources and their selects.
  input  wire logic       serial_tx_sel_i,
  input  wire logic       serial_tx_data_i,
  input  wire logic       timer_b_out_sel_i,
  input  wire logic       timer_b_out_i,
  input  wire logic       timer_a_out_sel_i,
  input  wire logic       timer_a_out_i,
  // Alternate inputs toward the peripherals.
  output logic      [3:0] ext_irq_in_0_o,
  output logic            timer_out_stop_in_o,
  output logic            adc_trigger_in_o,
  output logic            serial_rx_data_o,
  output logic            prog_mode_select_in_o,
  output logic      [3:0] analog_in_0_o,
  output logic            timer_b_in_o,
  output logic            ext_irq_in_5_o,
  output logic            timer_a_in_0_o,
  output logic            timer_a_in_1_o
);
  import gpg_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0] port0_latch_reg;
  logic [7:0] port1_latch_reg;
  logic [7:0] port5_latch_reg;
  logic [7:0] port0_direction_reg;
  logic [7:0] port1_direction_reg;
  logic [7:0] port5_direction_reg;
  logic [7:0] port0_pullup_reg;
  logic [7:0] port1_pullup_reg;
  logic [7:0] port5_pullup_reg;
  logic [7:0] port2_input_reg;
  logic [7:0] pin0_lvl;
  logic [7:0] pin1_lvl;
  logic [7:0] pin5_lvl;
  logic [7:0] port0_rd;
  logic [7:0] port1_rd;
  logic [7:0] port5_rd;
  logic [7:0] alt1_sel;
  logic [7:0] alt1_out;
  logic [7:0] alt5_sel;
  logic [7:0] alt5_out;
  logic [7:0] next_rdata;
  logic       next_hit;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
    is_addr = (a == r);
  endfunction : is_addr

  // ==========================================================================
  // Pin sampling
  // ==========================================================================
  // Pins are synchronous; one register stage gives a clean read value.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin0_lvl <= GPG_RST_LATCH;
      pin1_lvl <= GPG_RST_LATCH;
      pin5_lvl <= GPG_RST_LATCH;
    end else if (ce_i) begin
      pin0_lvl <= port0_pin_i & GPG_MASK_PT0;
      pin1_lvl <= port1_pin_i & GPG_MASK_PT1;
      pin5_lvl <= port5_pin_i & GPG_MASK_PT5;
    end
  end

  // Input-only port: no latch, no direction, no pull-up.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port2_input_reg <= GPG_RST_LATCH;
    end else if (ce_i) begin
      port2_input_reg <= port2_pin_i & GPG_MASK_PT2;
    end
  end

  // ==========================================================================
  // Alternate output steering
  // ==========================================================================
  always_comb begin
    alt1_sel = 8'h00;
    alt1_out = 8'h00;
    alt5_sel = 8'h00;
    alt5_out = 8'h00;
    alt1_sel[GPG_BIT_PT1_TX]  = serial_tx_sel_i;
    alt1_out[GPG_BIT_PT1_TX]  = serial_tx_data_i;
    alt5_sel[GPG_BIT_PT5_TB]  = timer_b_out_sel_i;
    alt5_out[GPG_BIT_PT5_TB]  = timer_b_out_i;
    alt5_sel[GPG_BIT_PT5_TAO] = timer_a_out_sel_i;
    alt5_out[GPG_BIT_PT5_TAO] = timer_a_out_i;
  end

  // ==========================================================================
  // Bidirectional ports
  // ==========================================================================
  gpg_port_slice #(.MASK(GPG_MASK_PT0)) u_port0 (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .wr_latch_i (sfr_wr_i && is_addr(sfr_addr_i, GPG_ADDR_PT0_LATCH)),
    .wr_dir_i   (sfr_wr_i && is_addr(sfr_addr_i, GPG_ADDR_PT0_DIR)),
    .wr_pu_i    (sfr_wr_i && is_addr(sfr_addr_i, GPG_ADDR_PT0_PU)),
    .wdata_i    (sfr_wdata_i),
    .pin_lvl_i  (pin0_lvl),
    .alt_sel_i  (8'h00),
    .alt_out_i  (8'h00),
    .latch_o    (port0_latch_reg),
    .dir_o      (port0_direction_reg),
    .pu_o       (port0_pullup_reg),
    .port_rd_o  (port0_rd),
    .pin_out_o  (port0_pin_o),
    .pin_oe_o   (port0_pin_oe_o),
    .pin_pu_o   (port0_pullup_o)
  );

  gpg_port_slice #(.MASK(GPG_MASK_PT1)) u_port1 (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .wr_latch_i (sfr_wr_i && is_addr(sfr_addr_i, GPG_ADDR_PT1_LATCH)),
    .wr_dir_i   (sfr_wr_i && is_addr(sfr_addr_i, GPG_ADDR_PT1_DIR)),
    .wr_pu_i    (sfr_wr_i && is_addr(sfr_addr_i, GPG_ADDR_PT1_PU)),
    .wdata_i    (sfr_wdata_i),
    .pin_lvl_i  (pin1_lvl),
    .alt_sel_i  (alt1_sel),
    .alt_out_i  (alt1_out),
    .latch_o    (port1_latch_reg),
    .dir_o      (port1_direction_reg),
    .pu_o       (port1_pullup_reg),
    .port_rd_o  (port1_rd),
    .pin_out_o  (port1_pin_o),
    .pin_oe_o   (port1_pin_oe_o),
    .pin_pu_o   (port1_pullup_o)
  );

  gpg_port_slice #(.MASK(GPG_MASK_PT5)) u_port5 (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .wr_latch_i (sfr_wr_i && is_addr(sfr_addr_i, GPG_ADDR_PT5_LATCH)),
    .wr_dir_i   (sfr_wr_i && is_addr(sfr_addr_i, GPG_ADDR_PT5_DIR)),
    .wr_pu_i    (sfr_wr_i && is_addr(sfr_addr_i, GPG_ADDR_PT5_PU)),
    .wdata_i    (sfr_wdata_i),
    .pin_lvl_i  (pin5_lvl),
    .alt_sel_i  (alt5_sel),
    .alt_out_i  (alt5_out),
    .latch_o    (port5_latch_reg),
    .dir_o      (port5_direction_reg),
    .pu_o       (port5_pullup_reg),
    .port_rd_o  (port5_rd),
    .pin_out_o  (port5_pin_o),
    .pin_oe_o   (port5_pin_oe_o),
    .pin_pu_o   (port5_pullup_o)
  );

  // ==========================================================================
  // Register read
  // ==========================================================================
  always_comb begin
    next_hit = 1'b1;
    case (sfr_addr_i)
      GPG_ADDR_PT0_LATCH: next_rdata = port0_rd;
      GPG_ADDR_PT1_LATCH: next_rdata = port1_rd;
      GPG_ADDR_PT2_INPUT: next_rdata = port2_input_reg;
      GPG_ADDR_PT5_LATCH: next_rdata = port5_rd;
      GPG_ADDR_PT0_DIR:   next_rdata = port0_direction_reg;
      GPG_ADDR_PT1_DIR:   next_rdata = port1_direction_reg;
      GPG_ADDR_PT5_DIR:   next_rdata = port5_direction_reg;
      GPG_ADDR_PT0_PU:    next_rdata = port0_pullup_reg;
      GPG_ADDR_PT1_PU:    next_rdata = port1_pullup_reg;
      GPG_ADDR_PT5_PU:    next_rdata = port5_pullup_reg;
      default: begin
        next_rdata = GPG_RST_RDATA;
        next_hit   = 1'b0;
      end
    endcase
  end

  // Read data is held until the next read.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sfr_rdata_o <= GPG_RST_RDATA;
      sfr_hit_o   <= 1'b0;
    end else if (ce_i && sfr_rd_i) begin
      sfr_rdata_o <= next_rdata;
      sfr_hit_o   <= next_hit;
    end
  end

  // ==========================================================================
  // Alternate inputs toward the peripherals
  // ==========================================================================
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_irq_in_0_o        <= 4'h0;
      timer_out_stop_in_o   <= 1'b0;
      adc_trigger_in_o      <= 1'b0;
      serial_rx_data_o      <= 1'b0;
      prog_mode_select_in_o <= 1'b0;
      analog_in_0_o         <= 4'h0;
      timer_b_in_o          <= 1'b0;
      ext_irq_in_5_o        <= 1'b0;
      timer_a_in_0_o        <= 1'b0;
      timer_a_in_1_o        <= 1'b0;
    end else if (ce_i) begin
      ext_irq_in_0_o        <= pin0_lvl[3:0];
      timer_out_stop_in_o   <= pin0_lvl[GPG_BIT_PT0_STOP];
      adc_trigger_in_o      <= pin0_lvl[GPG_BIT_PT0_TRIG];
      serial_rx_data_o      <= pin1_lvl[GPG_BIT_PT1_RX];
      prog_mode_select_in_o <= pin1_lvl[GPG_BIT_PT1_PROG];
      analog_in_0_o         <= port2_input_reg[3:0];
      timer_b_in_o          <= pin5_lvl[GPG_BIT_PT5_TB];
      ext_irq_in_5_o        <= pin5_lvl[GPG_BIT_PT5_IRQ5];
      timer_a_in_0_o        <= pin5_lvl[GPG_BIT_PT5_TA0];
      timer_a_in_1_o        <= pin5_lvl[GPG_BIT_PT5_TA1];
    end
  end

endmodule : gpg_port_group

// *** verilog/gpg_port_slice.sv ***
// One bidirectional port: latch, direction, pull-up and pin drive.
`timescale 1ns/1ps
module gpg_port_slice #(
  parameter logic [7:0] MASK = 8'hFF
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  input  wire logic       wr_latch_i,
  input  wire logic       wr_dir_i,
  input  wire logic       wr_pu_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] pin_lvl_i,
  input  wire logic [7:0] alt_sel_i,
  input  wire logic [7:0] alt_out_i,
  output logic      [7:0] latch_o,
  output logic      [7:0] dir_o,
  output logic      [7:0] pu_o,
  output logic      [7:0] port_rd_o,
  output logic      [7:0] pin_out_o,
  output logic      [7:0] pin_oe_o,
  output logic      [7:0] pin_pu_o
);
  import gpg_pkg::*;

  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;
  logic [7:0] next_pin_pu;

  // ==========================================================================
  // Software registers
  // ==========================================================================
  // Every write carries the whole byte; unimplemented bits stay constant.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_o <= GPG_RST_LATCH;
    end else if (ce_i && wr_latch_i) begin
      latch_o <= wdata_i & MASK;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_o <= GPG_RST_DIR;
    end else if (ce_i && wr_dir_i) begin
      dir_o <= wdata_i | ~MASK;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pu_o <= GPG_RST_PU;
    end else if (ce_i && wr_pu_i) begin
      pu_o <= wdata_i & MASK;
    end
  end

  // ==========================================================================
  // Read path and pin drive
  // ==========================================================================
  // Input bits show the pin, output bits show the latch.
  assign port_rd_o = ((pin_lvl_i & dir_o) | (latch_o & ~dir_o)) & MASK;

  always_comb begin
    next_pin_oe  = ~dir_o & MASK;
    next_pin_out = ((alt_sel_i & alt_out_i) | (~alt_sel_i & latch_o))
                   & next_pin_oe;
    next_pin_pu  = pu_o & dir_o & ~alt_sel_i & MASK;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_out_o <= GPG_RST_LATCH;
      pin_oe_o  <= GPG_RST_LATCH;
      pin_pu_o  <= GPG_RST_PU;
    end else if (ce_i) begin
      pin_out_o <= next_pin_out;
      pin_oe_o  <= next_pin_oe;
      pin_pu_o  <= next_pin_pu;
    end
  end

endmodule : gpg_port_slice
